/* hw/sso_pkg.sv */
// shared constants and types for the stack and stack-pointer load group
// assumes one processor clock where one clock state equals one sys_clk cycle
package sso_pkg;

    // opcode bytes
    localparam logic [7:0] OP_PFX_X = 8'hdd; // index x prefix
    localparam logic [7:0] OP_PFX_Y = 8'hfd; // index y prefix
    localparam logic [7:0] OP_NONE = 8'h00; // no prefix pending
    localparam logic [7:0] OP_STORE_DIRECT = 8'h22; // store index y direct
    localparam logic [7:0] OP_LOAD_SP = 8'hf9; // load stack pointer
    localparam logic [7:0] OP_PUSH_IDX = 8'he5; // push index register
    localparam logic [7:0] OP_POP_IDX = 8'he1; // pop index register
    localparam logic [7:0] OP_PAIR_MASK = 8'hcf; // hides the pair select field
    localparam logic [7:0] OP_PUSH_PAIR = 8'hc5; // 11 qq 0101
    localparam logic [7:0] OP_POP_PAIR = 8'hc1; // 11 qq 0001

    // pair select field codes and position
    localparam int PAIR_SEL_LSB = 4;
    localparam logic [1:0] PAIR_COUNTER = 2'h0;
    localparam logic [1:0] PAIR_DEST = 2'h1;
    localparam logic [1:0] PAIR_POINTER = 2'h2;
    localparam logic [1:0] PAIR_ACCUM_FLAGS = 2'h3;

    // preset port register selects
    localparam logic [2:0] SEL_COUNTER = 3'h0;
    localparam logic [2:0] SEL_DEST = 3'h1;
    localparam logic [2:0] SEL_POINTER = 3'h2;
    localparam logic [2:0] SEL_ACCUM_FLAGS = 3'h3;
    localparam logic [2:0] SEL_INDEX_X = 3'h4;
    localparam logic [2:0] SEL_INDEX_Y = 3'h5;
    localparam logic [2:0] SEL_STACK = 3'h6;
    localparam logic [2:0] SEL_PROG = 3'h7;

    // machine cycle lengths in clock states
    localparam logic [2:0] T_FETCH = 3'h4; // plain opcode fetch
    localparam logic [2:0] T_FETCH_PUSH = 3'h5; // fetch stretched before a push
    localparam logic [2:0] T_FETCH_LDSP = 3'h6; // fetch stretched for a pointer copy
    localparam logic [2:0] T_MEM = 3'h3; // memory read or write
    localparam logic [2:0] T_SAMPLE = 3'h1; // state in which read data is taken
    localparam logic [2:0] T_WR_STROBE = 3'h1; // state in which the write strobe fires

    // whole instruction lengths in clock states
    localparam logic [4:0] TOT_LDSP = 5'h06;
    localparam logic [4:0] TOT_LDSP_IDX = 5'h0a;
    localparam logic [4:0] TOT_STORE_Y = 5'h14;
    localparam logic [4:0] TOT_PUSH = 5'h0b;
    localparam logic [4:0] TOT_PUSH_IDX = 5'h0f;
    localparam logic [4:0] TOT_POP = 5'h0a;
    localparam logic [4:0] TOT_POP_IDX = 5'h0e;

    // values after reset
    localparam logic [15:0] RST_PROG = 16'h0000;
    localparam logic [15:0] RST_STACK = 16'h0000;
    localparam logic [15:0] RST_PAIR = 16'h0000;

    // instruction classes
    typedef enum logic [2:0] {K_LDSP, K_STORE_Y, K_PUSH, K_POP, K_PREFIX, K_OTHER} sso_kind_t;

    // machine cycle sequencer states
    typedef enum logic [2:0] {S_FETCH1, S_FETCH2, S_RD1, S_RD2, S_WR1, S_WR2} sso_state_t;

endpackage : sso_pkg

/* hw/sso_tim_if.sv */
// carrier between the sequencer and the clock state counter
// assumes both ends sit on the same sys_clk
`timescale 1ns/1ps
`default_nettype none
interface sso_tim_if;
    logic [2:0] len; // length of the current machine cycle
    logic [2:0] tstate; // clock state within the machine cycle, from 0
    logic last; // high in the final clock state of the machine cycle

    modport ctrl (output len, input tstate, input last);
    modport cnt (input len, output tstate, output last);
endinterface : sso_tim_if
`default_nettype wire

/* hw/sso_tstate.sv */
// clock state counter for one machine cycle at a time
// assumes the length stays steady from the state before the final one onward
`timescale 1ns/1ps
`default_nettype none
module sso_tstate (
    input wire logic sys_clk,
    input wire logic reset,
    sso_tim_if.cnt tim
);

    logic [2:0] tstate_reg; // current clock state

    // final state of the cycle when the count reaches one less than the length
    assign tim.last = (tstate_reg == tim.len - 3'h1);
    assign tim.tstate = tstate_reg;

    // count up and restart at each machine cycle boundary
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            tstate_reg <= 3'h0;
        end
        else if (tim.last)
        begin
            tstate_reg <= 3'h0;
        end
        else
        begin
            tstate_reg <= tstate_reg + 3'h1;
        end
    end

endmodule : sso_tstate
`default_nettype wire

/* hw/sso_core.sv */
// executes stack, push, pop and direct index store instructions from memory
// assumes a same-clock memory that answers a read one cycle after mem_rd
// Operation
// [RQ1] store index y decoded from FD 22
// [RQ2] low byte to target, high to target+1
// [RQ3] F9 copies pointer pair into stack pointer
// [RQ4] DD F9 copies index x, 4+6 states
// [RQ5] FD F9 copies index y, 4+6 states
// [RQ6] pair field: counter, dest, pointer, accum-flags
// [RQ7] push pair: decrement, high, decrement, low
// [RQ8] DD E5 pushes index x, 15 states
// [RQ9] FD E5 pushes index y, 15 states
// [RQ10] pop pair: low, increment, high, increment
// [RQ11] DD E1 pops index x, 14 states
// [RQ12] pop index y low then high, 14 states
// [RQ13] 16-bit stack pointer, stack grows downward
// [RQ14] no flag bit changes in this group; a pop of the accumulator-flags pair loads af_reg
// [RQ15] pop index y decoded from FD E1
// [RQ16] pointer and address arithmetic wraps silently
`timescale 1ns/1ps
`default_nettype none
module sso_core (
    input wire logic sys_clk,
    input wire logic reset,
    output logic [15:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    output logic cfg_ready,
    input wire logic cfg_we,
    input wire logic [2:0] cfg_sel,
    input wire logic [15:0] cfg_data,
    output logic insn_done,
    output logic unsupported,
    output logic [15:0] pair_counter,
    output logic [15:0] pair_dest,
    output logic [15:0] pair_pointer,
    output logic [15:0] pair_accum_flags,
    output logic [15:0] index_reg_x,
    output logic [15:0] index_reg_y,
    output logic [15:0] stack_top_pointer,
    output logic [15:0] prog_counter
);

    sso_tim_if tim (); // clock state carrier
    sso_pkg::sso_state_t state_reg; // machine cycle in progress
    sso_pkg::sso_state_t state_next; // machine cycle that follows
    sso_pkg::sso_kind_t kind; // class of the instruction being run
    logic [7:0] prefix_reg; // pending prefix byte or none
    logic [7:0] op_reg; // last opcode byte fetched
    logic [7:0] lo_reg; // first byte read from memory
    logic [7:0] hi_reg; // second byte read from memory
    logic [15:0] target_reg; // direct store address
    logic [15:0] pc_reg; // next instruction byte address
    logic [15:0] sp_reg; // stack top pointer
    logic [15:0] bc_reg; // counter pair
    logic [15:0] de_reg; // dest pair
    logic [15:0] hl_reg; // pointer pair
    logic [15:0] af_reg; // accumulator and flags pair
    logic [15:0] ix_reg; // index register x
    logic [15:0] iy_reg; // index register y
    logic done_reg; // end of instruction pulse
    logic unsup_reg; // unknown opcode pulse
    logic [15:0] idx_sel; // index register named by the prefix
    logic [15:0] push_src; // value being pushed
    logic is_fetch; // fetch machine cycle
    logic is_read; // fetch or data read machine cycle
    logic sample; // read data valid this state
    logic insn_end; // final state of the instruction
    logic [4:0] tot_cnt_reg; // clock states since the instruction began

    // classify an opcode given the prefix that precedes it
    function automatic sso_pkg::sso_kind_t sso_decode(input logic [7:0] pfx, input logic [7:0] op);
        sso_pkg::sso_kind_t k;
        k = sso_pkg::K_OTHER;
        if (pfx == sso_pkg::OP_NONE)
        begin
            if (op == sso_pkg::OP_PFX_X || op == sso_pkg::OP_PFX_Y)
                k = sso_pkg::K_PREFIX;
            else if (op == sso_pkg::OP_LOAD_SP)
                k = sso_pkg::K_LDSP; // RQ3
            else if ((op & sso_pkg::OP_PAIR_MASK) == sso_pkg::OP_PUSH_PAIR)
                k = sso_pkg::K_PUSH; // RQ7
            else if ((op & sso_pkg::OP_PAIR_MASK) == sso_pkg::OP_POP_PAIR)
                k = sso_pkg::K_POP; // RQ10
        end
        else if (pfx == sso_pkg::OP_PFX_Y && op == sso_pkg::OP_STORE_DIRECT)
            k = sso_pkg::K_STORE_Y; // RQ1
        else if (op == sso_pkg::OP_LOAD_SP)
            k = sso_pkg::K_LDSP; // RQ4 RQ5
        else if (op == sso_pkg::OP_PUSH_IDX)
            k = sso_pkg::K_PUSH; // RQ8 RQ9
        else if (op == sso_pkg::OP_POP_IDX)
            k = sso_pkg::K_POP; // RQ11 RQ15
        return k;
    endfunction : sso_decode

    // pick a register pair by its two bit select field
    function automatic logic [15:0] sso_pair_pick(input logic [1:0] sel, input logic [15:0] bc,
        input logic [15:0] de, input logic [15:0] hl, input logic [15:0] af);
        logic [15:0] v;
        case (sel)
            sso_pkg::PAIR_COUNTER: v = bc;
            sso_pkg::PAIR_DEST: v = de;
            sso_pkg::PAIR_POINTER: v = hl;
            default: v = af;
        endcase
        return v;
    endfunction : sso_pair_pick

    // expected length in states of a whole instruction
    function automatic logic [4:0] sso_total(input sso_pkg::sso_kind_t k, input logic pfx);
        logic [4:0] t;
        case (k)
            sso_pkg::K_LDSP: t = pfx ? sso_pkg::TOT_LDSP_IDX : sso_pkg::TOT_LDSP;
            sso_pkg::K_STORE_Y: t = sso_pkg::TOT_STORE_Y;
            sso_pkg::K_PUSH: t = pfx ? sso_pkg::TOT_PUSH_IDX : sso_pkg::TOT_PUSH;
            sso_pkg::K_POP: t = pfx ? sso_pkg::TOT_POP_IDX : sso_pkg::TOT_POP;
            default: t = 5'h00;
        endcase
        return t;
    endfunction : sso_total

    sso_tstate u_tstate (
        .sys_clk(sys_clk),
        .reset(reset),
        .tim(tim)
    );

    // decode from the byte in op_reg; the first fetch never sees a prefix
    assign kind = sso_decode((state_reg == sso_pkg::S_FETCH1) ? sso_pkg::OP_NONE : prefix_reg, op_reg);
    assign idx_sel = (prefix_reg == sso_pkg::OP_PFX_Y) ? iy_reg : ix_reg;
    assign push_src = (prefix_reg == sso_pkg::OP_NONE) ?
        sso_pair_pick(op_reg[sso_pkg::PAIR_SEL_LSB +: 2], bc_reg, de_reg, hl_reg, af_reg) : idx_sel; // RQ6
    assign is_fetch = (state_reg == sso_pkg::S_FETCH1) || (state_reg == sso_pkg::S_FETCH2);
    assign is_read = is_fetch || (state_reg == sso_pkg::S_RD1) || (state_reg == sso_pkg::S_RD2);
    assign sample = is_read && (tim.tstate == sso_pkg::T_SAMPLE);
    assign insn_end = tim.last && (state_next == sso_pkg::S_FETCH1);

    // machine cycle length: fetches stretch once the opcode is known
    always_comb
    begin
        if (!is_fetch)
            tim.len = sso_pkg::T_MEM;
        else if (tim.tstate <= sso_pkg::T_SAMPLE)
            tim.len = sso_pkg::T_FETCH; // opcode not yet in op_reg
        else if (kind == sso_pkg::K_LDSP)
            tim.len = sso_pkg::T_FETCH_LDSP; // RQ3 RQ4 RQ5
        else if (kind == sso_pkg::K_PUSH)
            tim.len = sso_pkg::T_FETCH_PUSH; // RQ7 RQ8 RQ9
        else
            tim.len = sso_pkg::T_FETCH;
    end

    // bus drive: request in state 0, write strobe in its own state
    always_comb
    begin
        mem_rd = is_read && (tim.tstate == 3'h0);
        mem_wr = ((state_reg == sso_pkg::S_WR1) || (state_reg == sso_pkg::S_WR2)) &&
            (tim.tstate == sso_pkg::T_WR_STROBE);
        mem_wdata = 8'h00;
        if (is_fetch || (is_read && kind == sso_pkg::K_STORE_Y))
            mem_addr = pc_reg; // opcode and operand bytes
        else if (kind == sso_pkg::K_STORE_Y)
            mem_addr = target_reg; // RQ2
        else
            mem_addr = sp_reg; // RQ13
        if (state_reg == sso_pkg::S_WR1)
            mem_wdata = (kind == sso_pkg::K_STORE_Y) ? iy_reg[7:0] : push_src[15:8]; // RQ2 RQ7
        else if (state_reg == sso_pkg::S_WR2)
            mem_wdata = (kind == sso_pkg::K_STORE_Y) ? iy_reg[15:8] : push_src[7:0]; // RQ2 RQ7
    end

    // next machine cycle chosen by the instruction class
    always_comb
    begin
        state_next = sso_pkg::S_FETCH1;
        case (state_reg)
            sso_pkg::S_FETCH1,
            sso_pkg::S_FETCH2:
            begin
                if (kind == sso_pkg::K_PREFIX)
                    state_next = sso_pkg::S_FETCH2;
                else if (kind == sso_pkg::K_PUSH)
                    state_next = sso_pkg::S_WR1;
                else if (kind == sso_pkg::K_POP || kind == sso_pkg::K_STORE_Y)
                    state_next = sso_pkg::S_RD1;
            end
            sso_pkg::S_RD1: state_next = sso_pkg::S_RD2;
            sso_pkg::S_RD2: state_next = (kind == sso_pkg::K_STORE_Y) ? sso_pkg::S_WR1 : sso_pkg::S_FETCH1;
            sso_pkg::S_WR1: state_next = sso_pkg::S_WR2;
            default: state_next = sso_pkg::S_FETCH1;
        endcase
    end

    // machine cycle sequencer
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            state_reg <= sso_pkg::S_FETCH1;
        else if (tim.last)
            state_reg <= state_next;
    end

    // opcode, prefix and read data capture
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            op_reg <= 8'h00;
            prefix_reg <= sso_pkg::OP_NONE;
            lo_reg <= 8'h00;
            hi_reg <= 8'h00;
        end
        else
        begin
            if (sample && is_fetch)
                op_reg <= mem_rdata;
            else if (sample && state_reg == sso_pkg::S_RD1)
                lo_reg <= mem_rdata; // RQ1 RQ10 first byte is the low byte
            else if (sample && state_reg == sso_pkg::S_RD2)
                hi_reg <= mem_rdata;
            if (tim.last && state_reg == sso_pkg::S_FETCH1)
                prefix_reg <= (kind == sso_pkg::K_PREFIX) ? op_reg : sso_pkg::OP_NONE;
        end
    end

    // program counter steps past each opcode and operand byte
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            pc_reg <= sso_pkg::RST_PROG;
        else if (cfg_ready && cfg_we && cfg_sel == sso_pkg::SEL_PROG)
            pc_reg <= cfg_data;
        else if (mem_rd && mem_addr == pc_reg && (is_fetch || kind == sso_pkg::K_STORE_Y))
            pc_reg <= pc_reg + 16'h0001;
    end

    // direct store address, then the byte above it
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            target_reg <= 16'h0000;
        else if (tim.last && kind == sso_pkg::K_STORE_Y && state_reg == sso_pkg::S_RD2)
            target_reg <= {hi_reg, lo_reg}; // RQ1
        else if (tim.last && kind == sso_pkg::K_STORE_Y && state_reg == sso_pkg::S_WR1)
            target_reg <= target_reg + 16'h0001; // RQ2 RQ16
    end

    // stack pointer: copies, pre-decrement on push, post-increment on pop
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            sp_reg <= sso_pkg::RST_STACK;
        else if (cfg_ready && cfg_we && cfg_sel == sso_pkg::SEL_STACK)
            sp_reg <= cfg_data;
        else if (tim.last)
        begin
            if (is_fetch && kind == sso_pkg::K_LDSP)
                sp_reg <= (prefix_reg == sso_pkg::OP_NONE || state_reg == sso_pkg::S_FETCH1) ?
                    hl_reg : idx_sel; // RQ3 RQ4 RQ5
            else if ((is_fetch || state_reg == sso_pkg::S_WR1) && kind == sso_pkg::K_PUSH)
                sp_reg <= sp_reg - 16'h0001; // RQ7 RQ13 RQ16
            else if ((state_reg == sso_pkg::S_RD1 || state_reg == sso_pkg::S_RD2) && kind == sso_pkg::K_POP)
                sp_reg <= sp_reg + 16'h0001; // RQ10 RQ16
        end
    end

    // register pairs and index registers: preset or pop
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            bc_reg <= sso_pkg::RST_PAIR;
            de_reg <= sso_pkg::RST_PAIR;
            hl_reg <= sso_pkg::RST_PAIR;
            af_reg <= sso_pkg::RST_PAIR;
            ix_reg <= sso_pkg::RST_PAIR;
            iy_reg <= sso_pkg::RST_PAIR;
        end
        else if (cfg_ready && cfg_we)
        begin
            case (cfg_sel)
                sso_pkg::SEL_COUNTER: bc_reg <= cfg_data;
                sso_pkg::SEL_DEST: de_reg <= cfg_data;
                sso_pkg::SEL_POINTER: hl_reg <= cfg_data;
                sso_pkg::SEL_ACCUM_FLAGS: af_reg <= cfg_data;
                sso_pkg::SEL_INDEX_X: ix_reg <= cfg_data;
                sso_pkg::SEL_INDEX_Y: iy_reg <= cfg_data;
                default: ;
            endcase
        end
        else if (tim.last && state_reg == sso_pkg::S_RD2 && kind == sso_pkg::K_POP)
        begin
            // flags only move when the accumulator pair itself is popped
            if (prefix_reg == sso_pkg::OP_PFX_X)
                ix_reg <= {hi_reg, lo_reg}; // RQ11
            else if (prefix_reg == sso_pkg::OP_PFX_Y)
                iy_reg <= {hi_reg, lo_reg}; // RQ12 RQ15
            else
            begin
                case (op_reg[sso_pkg::PAIR_SEL_LSB +: 2])
                    sso_pkg::PAIR_COUNTER: bc_reg <= {hi_reg, lo_reg}; // RQ6
                    sso_pkg::PAIR_DEST: de_reg <= {hi_reg, lo_reg};
                    sso_pkg::PAIR_POINTER: hl_reg <= {hi_reg, lo_reg};
                    default: af_reg <= {hi_reg, lo_reg}; // RQ14
                endcase
            end
        end
    end

    // status pulses at the end of each instruction
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            done_reg <= 1'b0;
            unsup_reg <= 1'b0;
        end
        else
        begin
            done_reg <= insn_end;
            unsup_reg <= insn_end && kind == sso_pkg::K_OTHER;
        end
    end

    // states elapsed within the current instruction, checked below
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            tot_cnt_reg <= 5'h00;
        else if (insn_end)
            tot_cnt_reg <= 5'h00;
        else
            tot_cnt_reg <= tot_cnt_reg + 5'h01;
    end

    assign cfg_ready = (state_reg == sso_pkg::S_FETCH1) && (tim.tstate == 3'h0);
    assign insn_done = done_reg;
    assign unsupported = unsup_reg;
    assign pair_counter = bc_reg;
    assign pair_dest = de_reg;
    assign pair_pointer = hl_reg;
    assign pair_accum_flags = af_reg;
    assign index_reg_x = ix_reg;
    assign index_reg_y = iy_reg;
    assign stack_top_pointer = sp_reg;
    assign prog_counter = pc_reg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_fetch2_end;
        state_reg == sso_pkg::S_FETCH2 && tim.last;
    endsequence
    sequence s_push_first_write;
        state_reg == sso_pkg::S_WR1 && kind == sso_pkg::K_PUSH && tim.tstate == 3'h0;
    endsequence

    a_store_decode: // RQ1
    assert property (s_fetch2_end ##0 (prefix_reg == sso_pkg::OP_PFX_Y && op_reg == sso_pkg::OP_STORE_DIRECT)
        |=> state_reg == sso_pkg::S_RD1)
        else $error("store index y not decoded");
    a_store_high_byte: // RQ2
    assert property (state_reg == sso_pkg::S_WR2 && kind == sso_pkg::K_STORE_Y && mem_wr
        |-> mem_wdata == iy_reg[15:8] && mem_addr == {hi_reg, lo_reg} + 16'h0001)
        else $error("store high byte misplaced");
    a_ldsp_pointer: // RQ3
    assert property (state_reg == sso_pkg::S_FETCH1 && tim.last && kind == sso_pkg::K_LDSP
        |=> sp_reg == $past(hl_reg) && state_reg == sso_pkg::S_FETCH1)
        else $error("pointer pair copy wrong");
    a_ldsp_index: // RQ4
    assert property (s_fetch2_end ##0 kind == sso_pkg::K_LDSP |=> sp_reg == $past(idx_sel))
        else $error("index copy to stack pointer wrong");
    a_push_order: // RQ7
    assert property (s_push_first_write |-> ##1 mem_wr && mem_wdata == push_src[15:8]
        ##3 mem_wr && mem_wdata == push_src[7:0] && mem_addr == sp_reg)
        else $error("push byte order wrong");
    a_push_pair_sel: // RQ6
    assert property (s_push_first_write and (prefix_reg == sso_pkg::OP_NONE
        && op_reg[sso_pkg::PAIR_SEL_LSB +: 2] == sso_pkg::PAIR_DEST) |-> push_src == de_reg)
        else $error("pair select decode wrong");
    a_insn_length: // RQ8
    assert property (insn_end && kind != sso_pkg::K_OTHER && kind != sso_pkg::K_PREFIX
        |-> tot_cnt_reg == sso_total(kind, state_reg != sso_pkg::S_FETCH1 && prefix_reg != sso_pkg::OP_NONE) - 5'h01)
        else $error("instruction state count wrong");
    a_pop_increment: // RQ10
    assert property (state_reg == sso_pkg::S_RD1 && tim.tstate == 3'h0 && kind == sso_pkg::K_POP
        |-> ##6 sp_reg == $past(sp_reg, 6) + 16'h0002)
        else $error("pop did not step stack pointer by two");
    a_pop_low_first: // RQ11
    assert property (state_reg == sso_pkg::S_RD2 && tim.last && kind == sso_pkg::K_POP
        && prefix_reg == sso_pkg::OP_PFX_X |=> ix_reg == {$past(hi_reg), $past(lo_reg)})
        else $error("pop byte order wrong");
    a_stack_wrap: // RQ16
    assert property (s_push_first_write and (sp_reg == 16'h0000) |-> ##5 sp_reg == 16'hffff)
        else $error("stack pointer wrap wrong");
    a_flags_hold: // RQ14
    assert property (af_reg != $past(af_reg) |-> $past(cfg_we && cfg_ready)
        || $past(state_reg == sso_pkg::S_RD2 && kind == sso_pkg::K_POP))
        else $error("flags changed unexpectedly");

endmodule : sso_core
`default_nettype wire

/* sim/sso_mem_model.sv */
// byte memory on the far side of the bus
// assumes one sys_clk; a read is answered one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module sso_mem_model (
    input wire logic sys_clk,
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] ram [0:65535]; // storage, also loaded by the bench
    // answer a read next cycle, otherwise show a value that keeps changing
    // plain always: the bench also loads ram, which always_ff would forbid
    always @(posedge sys_clk)
    begin
        mem_rdata <= mem_rd ? ram[mem_addr] : ~mem_rdata;
        if (mem_wr)
            ram[mem_addr] <= mem_wdata;
    end
endmodule : sso_mem_model
`default_nettype wire

/* sim/test_sso_core.sv */
// self-checking bench for the stack and pointer load group
// assumes the memory model answers reads one cycle late
`timescale 1ns/1ps
`default_nettype none
module test_sso_core;
    logic sys_clk = 1'b0; // 50 ns period
    logic reset = 1'b1; // held for 10 cycles
    logic cfg_we = 1'b0;
    logic [2:0] cfg_sel = 3'h0;
    logic [15:0] cfg_data = 16'h0000;
    logic [15:0] mem_addr;
    logic mem_rd, mem_wr, cfg_ready, insn_done, unsupported;
    logic [7:0] mem_wdata, mem_rdata;
    logic [15:0] obs [8]; // register outputs in select-code order
    logic [15:0] e [8]; // expected registers
    logic [15:0] stk [$]; // words pushed, newest last
    logic [15:0] a; // store target
    logic [31:0] seed = 32'hf037763f;
    int bad_count = 0;
    int total_checks = 0;
    int cyc = 0;
    sso_core dut (.sys_clk, .reset, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .cfg_ready,
        .cfg_we, .cfg_sel, .cfg_data, .insn_done, .unsupported, .pair_counter(obs[0]), .pair_dest(obs[1]),
        .pair_pointer(obs[2]), .pair_accum_flags(obs[3]), .index_reg_x(obs[4]), .index_reg_y(obs[5]),
        .stack_top_pointer(obs[6]), .prog_counter(obs[7]));
    sso_mem_model ram_side (.sys_clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);
    always #25 sys_clk = ~sys_clk;
    // cut a hang short
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            summarize();
        end
    end
    function automatic logic [15:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[15:0];
    endfunction : rnd
    task automatic chk(input logic [15:0] s, input logic [15:0] x);
        total_checks++;
        if (s !== x)
            $display("wrong value at %0t: saw %h expected %h", $time, s, x);
        if (s !== x)
            bad_count++;
    endtask : chk
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize
    // little-endian word in memory
    task automatic mw(input logic [15:0] ad, input logic [15:0] v);
        chk({ram_side.ram[ad + 16'h0001], ram_side.ram[ad]}, v);
    endtask : mw
    // run one instruction from the expected pc, optional preset at its boundary
    task automatic ex(input logic [31:0] op, input int n, input int ts, input logic w = 1'b0,
        input logic [2:0] sl = 3'h0, input logic [15:0] d = 16'h0000);
        int k;
        for (k = 0; k < n; k++)
            ram_side.ram[e[7] + 16'(k)] = op[31 - 8 * k -: 8];
        cfg_we = w;
        cfg_sel = sl;
        cfg_data = d;
        k = 0;
        do
        begin
            @(posedge sys_clk);
            #5;
            cfg_we = 1'b0;
            k++;
        end while (insn_done !== 1'b1 && k < 40);
        chk(16'(k), 16'(ts));
        chk(16'(unsupported), 16'(op[31:24] == 8'h00));
        e[7] += 16'(n);
        if (w)
            e[sl] = d;
        for (k = 0; k < 8; k++)
            chk(obs[k], e[k]);
    endtask : ex
    initial
    begin
        for (int i = 0; i < 8; i++)
            e[i] = 16'h0000;
        repeat (10) @(posedge sys_clk);
        #5;
        reset = 1'b0;
        for (int r = 0; r < 6; r++)
        begin
            for (int s = 0; s < 6; s++)
                ex(32'h0, 1, 4, 1'b1, 3'(s), rnd());
            e[6] = e[2];
            ex(32'hf9000000, 1, 6);
            e[6] = e[4];
            ex(32'hddf90000, 2, 10);
            e[6] = e[5];
            ex(32'hfdf90000, 2, 10);
            ex(32'h0, 1, 4, 1'b1, 3'h6, r == 0 ? 16'h0001 : rnd() | 16'h8000);
            for (int q = 0; q < 6; q++)
            begin
                stk.push_back(e[q]);
                e[6] -= 16'h0002;
                ex(q < 4 ? {2'b11, 2'(q), 4'h5, 24'h0} : {q == 4 ? 8'hdd : 8'hfd, 24'he50000}, q < 4 ? 1 : 2,
                    q < 4 ? 11 : 15);
                mw(e[6], stk[$]);
            end
            for (int j = 0; j < 6; j++)
            begin
                e[(j + 4) % 6] = stk.pop_back();
                e[6] += 16'h0002;
                ex(j < 2 ? {j == 0 ? 8'hdd : 8'hfd, 24'he10000} : {2'b11, 2'(j - 2), 4'h1, 24'h0}, j < 2 ? 2 : 1,
                    j < 2 ? 14 : 10);
            end
            a = r == 0 ? 16'hffff : rnd() | 16'h8000;
            ex({8'hfd, 8'h22, a[7:0], a[15:8]}, 4, 20);
            mw(a, e[5]);
            $display("round %0d done", r);
        end
        summarize();
    end
endmodule : test_sso_core
`default_nettype wire
